// >>> common/mrd_pkg.sv
// constants and types for the motion relay delay controller
package mrd_pkg;

    // clock rate and one-second time base
    localparam int unsigned CLK_FREQ_HZ  = 100_000_000;
    localparam int unsigned TICK_TIME_MS = 1000;
    localparam int unsigned TICK_CYCLES  = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;

    // behaviour times, counted in seconds
    localparam logic [11:0] SMART_TIME_S  = 12'h00A;  // 10 s first window
    localparam logic [1:0]  SAMPLE_TIME_S = 2'h3;     // 3 s per setting sample
    localparam logic [11:0] LONG_DELAY_S  = 12'h12C;  // 5 min
    localparam logic [11:0] LAST_WINDOW_S = 12'h03C;  // final minute

    // setting quantisation: 16 raw levels, top two merged
    localparam logic [3:0] LEVEL_TOP   = 4'hE;
    localparam logic [3:0] LEVEL_RESET = 4'h0;

    // analog conversion: code width, reference and light threshold
    localparam int unsigned ADC_BITS     = 10;
    localparam int unsigned VREF_MV      = 2200;
    localparam int unsigned LIGHT_THR_MV = 1400;

    // register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LEVELS = 4'h8;
    localparam logic [3:0] REG_REMAIN = 4'hC;

    // control field positions and reset value
    localparam int unsigned CTRL_SMART_BIT = 0;
    localparam int unsigned CTRL_DDET_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h3;

    // relay run phases, gray along off -> short -> full
    typedef enum logic [1:0] {
        RUN_OFF   = 2'b00,
        RUN_SMART = 2'b01,
        RUN_FULL  = 2'b11
    } mrd_run_t;

    // delay level to run time in seconds
    function automatic logic [11:0] delay_secs(input logic [3:0] lvl);
        case (lvl)
            4'h0:    delay_secs = 12'h00A;
            4'h1:    delay_secs = 12'h014;
            4'h2:    delay_secs = 12'h01E;
            4'h3:    delay_secs = 12'h02D;
            4'h4:    delay_secs = 12'h03C;
            4'h5:    delay_secs = 12'h05A;
            4'h6:    delay_secs = 12'h078;
            4'h7:    delay_secs = 12'h0B4;
            4'h8:    delay_secs = 12'h0F0;
            4'h9:    delay_secs = 12'h12C;
            4'hA:    delay_secs = 12'h1A4;
            4'hB:    delay_secs = 12'h258;
            4'hC:    delay_secs = 12'h384;
            4'hD:    delay_secs = 12'h4B0;
            default: delay_secs = 12'h708;
        endcase
    endfunction

endpackage

// >>> hdl/mrd_relay_ctrl.sv
// motion driven relay run-time controller with setting sampler
//
// Behaviour
// - motion while the relay is off and light allows it starts a run of at most 10 s.
// - motion inside that short run extends it to the full selected delay.
// - without further motion the short run ends and the relay drops.
// - with delayed detection on and a delay of 5 min or more, motion is ignored until the last minute.
// - with delayed detection off, every new motion retriggers the run at once.
// - the short-run and delayed-detection behaviours have their own enable bits.
// - sensitivity and delay settings are sampled in turn, one every 3 s.
// - each setting is cut to 16 levels and the top two are merged into 15 settings.
// - the ambient light level is sampled when motion arrives to decide turn-on.
// - the relay starts only when the light sample is at or above the 1.4 V threshold.
// - once running, retriggers ignore the light level.
// - the relay output is high to energise the coil and low to release it.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module mrd_relay_ctrl #(
    parameter int unsigned TICK_CYCLES = mrd_pkg::TICK_CYCLES,
    parameter int unsigned ADC_W       = mrd_pkg::ADC_BITS
) (
    // clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RST_N_I,
    // register port
    input  wire logic [3:0]        REG_ADDR_I,
    input  wire logic [31:0]       REG_WDATA_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    output logic      [31:0]       REG_RDATA_O,
    // motion engine
    input  wire logic              MOTION_EVT_I,
    output logic      [3:0]        SENS_LEVEL_O,
    // digitised analog levels from pins
    input  wire logic [ADC_W-1:0]  SENS_SETTING_I,
    input  wire logic [ADC_W-1:0]  DELAY_SETTING_I,
    input  wire logic [ADC_W-1:0]  AMBIENT_LIGHT_I,
    // relay coil driver
    output logic                   RELAY_DRIVE_O
);
    import mrd_pkg::*;

    localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [ADC_W-1:0] LIGHT_THR =
        ADC_W'(LIGHT_THR_MV * (2 ** ADC_W) / VREF_MV);

    // synchroniser stages, then a copy kept once two samples agree
    logic [ADC_W-1:0] sens_m_q;
    logic [ADC_W-1:0] sens_s_q;
    logic [ADC_W-1:0] sens_t_q;
    logic [ADC_W-1:0] sens_v_q;
    logic [ADC_W-1:0] dly_m_q;
    logic [ADC_W-1:0] dly_s_q;
    logic [ADC_W-1:0] dly_t_q;
    logic [ADC_W-1:0] dly_v_q;
    logic [ADC_W-1:0] amb_m_q;
    logic [ADC_W-1:0] amb_s_q;
    logic [ADC_W-1:0] amb_t_q;
    logic [ADC_W-1:0] amb_v_q;

    // control and sampler state
    logic             smart_en_q;
    logic             ddet_en_q;
    logic [DIV_W-1:0] samp_div_q;
    logic [1:0]       samp_sec_q;
    logic             samp_sel_q;
    logic [3:0]       delay_lvl_q;
    logic             samp_tick;

    // run state
    mrd_run_t         run_q;
    mrd_run_t         run_d;
    logic [11:0]      rem_q;
    logic [11:0]      rem_d;
    logic [DIV_W-1:0] run_div_q;
    logic             reload;
    logic             run_tick;
    logic             light_ok;
    logic             light_evt_q;
    logic [11:0]      delay_s;
    logic [11:0]      smart_s;
    logic             long_hold;

    // cut a conversion to a setting level
    function automatic logic [3:0] quant(input logic [ADC_W-1:0] v);
        logic [3:0] raw;
        raw = v[ADC_W-1 -: 4];
        quant = (raw == 4'hF) ? LEVEL_TOP : raw;
    endfunction

    // two-stage synchronisers on the analog level buses
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sens_m_q <= '0;
            sens_s_q <= '0;
            dly_m_q  <= '0;
            dly_s_q  <= '0;
            amb_m_q  <= '0;
            amb_s_q  <= '0;
        end else begin
            sens_m_q <= SENS_SETTING_I;
            sens_s_q <= sens_m_q;
            dly_m_q  <= DELAY_SETTING_I;
            dly_s_q  <= dly_m_q;
            amb_m_q  <= AMBIENT_LIGHT_I;
            amb_s_q  <= amb_m_q;
        end
    end

    // keep a code only when two synchronised samples agree, so a word
    // caught mid-change by the flops is never used
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sens_t_q <= '0;
            sens_v_q <= '0;
            dly_t_q  <= '0;
            dly_v_q  <= '0;
            amb_t_q  <= '0;
            amb_v_q  <= '0;
        end else begin
            sens_t_q <= sens_s_q;
            dly_t_q  <= dly_s_q;
            amb_t_q  <= amb_s_q;
            if (sens_s_q == sens_t_q) begin
                sens_v_q <= sens_s_q;
            end
            if (dly_s_q == dly_t_q) begin
                dly_v_q <= dly_s_q;
            end
            if (amb_s_q == amb_t_q) begin
                amb_v_q <= amb_s_q;
            end
        end
    end

    // control register write
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            smart_en_q <= CTRL_RESET[CTRL_SMART_BIT];
            ddet_en_q  <= CTRL_RESET[CTRL_DDET_BIT];
        end else if (REG_WR_I && REG_ADDR_I == REG_CTRL) begin
            smart_en_q <= REG_WDATA_I[CTRL_SMART_BIT];
            ddet_en_q  <= REG_WDATA_I[CTRL_DDET_BIT];
        end
    end

    // three-second sample timer
    assign samp_tick = (samp_div_q == DIV_LAST) &&
                       (samp_sec_q == SAMPLE_TIME_S - 2'h1);

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            samp_div_q <= '0;
            samp_sec_q <= '0;
        end else if (samp_div_q == DIV_LAST) begin
            samp_div_q <= '0;
            samp_sec_q <= samp_tick ? 2'h0 : samp_sec_q + 2'h1;
        end else begin
            samp_div_q <= samp_div_q + DIV_W'(1);
        end
    end

    // alternate sampling of sensitivity and delay settings
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            samp_sel_q   <= 1'b0;
            SENS_LEVEL_O <= LEVEL_RESET;
            delay_lvl_q  <= LEVEL_RESET;
        end else if (samp_tick) begin
            samp_sel_q <= ~samp_sel_q;
            if (samp_sel_q) begin
                delay_lvl_q <= quant(dly_v_q);
            end else begin
                SENS_LEVEL_O <= quant(sens_v_q);
            end
        end
    end

    // run-time figures for the current setting
    assign delay_s   = delay_secs(delay_lvl_q);
    assign smart_s   = (delay_s < SMART_TIME_S) ? delay_s : SMART_TIME_S;
    assign light_ok  = (amb_v_q >= LIGHT_THR);
    assign long_hold = ddet_en_q && (delay_s >= LONG_DELAY_S) &&
                       (rem_q > LAST_WINDOW_S);
    assign run_tick  = (run_div_q == DIV_LAST);

    // next run phase and remaining seconds
    always_comb begin
        run_d  = run_q;
        rem_d  = rem_q;
        reload = 1'b0;
        if (run_tick && rem_q != 12'h000) begin
            rem_d = rem_q - 12'h001;
        end
        if (run_tick && rem_q == 12'h001) begin
            run_d = RUN_OFF;
        end
        case (run_q)
            RUN_OFF: begin
                if (MOTION_EVT_I && light_ok) begin
                    run_d  = smart_en_q ? RUN_SMART : RUN_FULL;
                    rem_d  = smart_en_q ? smart_s : delay_s;
                    reload = 1'b1;
                end
            end
            RUN_SMART: begin
                if (MOTION_EVT_I) begin
                    run_d  = RUN_FULL;
                    rem_d  = delay_s;
                    reload = 1'b1;
                end
            end
            RUN_FULL: begin
                if (MOTION_EVT_I && !long_hold) begin
                    run_d  = RUN_FULL;
                    rem_d  = delay_s;
                    reload = 1'b1;
                end
            end
            default: begin
                run_d = RUN_OFF;
                rem_d = 12'h000;
            end
        endcase
    end

    // run state, second prescaler restarted at each accepted event
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_q     <= RUN_OFF;
            rem_q     <= 12'h000;
            run_div_q <= '0;
        end else begin
            run_q <= run_d;
            rem_q <= rem_d;
            if (reload || run_tick) begin
                run_div_q <= '0;
            end else begin
                run_div_q <= run_div_q + DIV_W'(1);
            end
        end
    end

    // coil drive and light sample seen at the last motion
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RELAY_DRIVE_O <= 1'b0;
            light_evt_q   <= 1'b0;
        end else begin
            RELAY_DRIVE_O <= (run_d != RUN_OFF);
            if (MOTION_EVT_I) begin
                light_evt_q <= light_ok;
            end
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 32'h0000_0000;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                REG_CTRL:   REG_RDATA_O <= {30'h0, ddet_en_q, smart_en_q};
                REG_STATUS: REG_RDATA_O <= {27'h0, light_evt_q, samp_sel_q,
                                            run_q, RELAY_DRIVE_O};
                REG_LEVELS: REG_RDATA_O <= {24'h0, delay_lvl_q, SENS_LEVEL_O};
                REG_REMAIN: REG_RDATA_O <= {20'h0, rem_q};
                default:    REG_RDATA_O <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA_O <= 32'h0000_0000;
        end
    end

    // checks on the run logic, the setting sampler and the light sample
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    short_start_a: assert property (
        run_q == RUN_OFF && MOTION_EVT_I && light_ok && smart_en_q
        |=> run_q == RUN_SMART && rem_q == $past(smart_s) &&
            rem_q <= SMART_TIME_S)
        else $error("short run not started with capped time");

    short_extend_a: assert property (
        run_q == RUN_SMART && MOTION_EVT_I
        |=> run_q == RUN_FULL && rem_q == $past(delay_s))
        else $error("short run not extended to full delay");

    short_expire_a: assert property (
        run_q == RUN_SMART && run_tick && rem_q == 12'h001 && !MOTION_EVT_I
        |=> run_q == RUN_OFF ##0 !RELAY_DRIVE_O)
        else $error("short run did not end");

    long_ignore_a: assert property (
        run_q == RUN_FULL && MOTION_EVT_I && ddet_en_q && !run_tick &&
        delay_s >= LONG_DELAY_S && rem_q > LAST_WINDOW_S
        |=> rem_q == $past(rem_q))
        else $error("motion accepted during hold-off");

    free_retrig_a: assert property (
        run_q == RUN_FULL && MOTION_EVT_I && !ddet_en_q
        |=> rem_q == $past(delay_s) && run_div_q == '0)
        else $error("retrigger not taken");

    sample_turn_a: assert property (
        samp_tick |=> samp_sel_q != $past(samp_sel_q) ##1 !samp_tick)
        else $error("sample select did not alternate");

    level_merge_a: assert property (
        delay_lvl_q <= LEVEL_TOP && SENS_LEVEL_O <= LEVEL_TOP)
        else $error("setting level above merged top");

    dark_stay_a: assert property (
        run_q == RUN_OFF && MOTION_EVT_I && !light_ok
        |=> run_q == RUN_OFF && !RELAY_DRIVE_O)
        else $error("relay started below light threshold");

    relay_level_a: assert property (
        RELAY_DRIVE_O == (run_q != RUN_OFF))
        else $error("coil drive disagrees with run state");

    light_ignore_a: assert property (
        run_q == RUN_SMART && MOTION_EVT_I && !light_ok |=> run_q == RUN_FULL)
        else $error("retrigger consulted light level");

    light_catch_a: assert property (
        MOTION_EVT_I |=> light_evt_q == $past(light_ok))
        else $error("light not sampled on motion");

endmodule

`default_nettype wire

// >>> dv/mrd_partner.sv
// motion engine and analog front end model for the relay controller
`timescale 1ns/1ps
`default_nettype none

module mrd_partner #(
    parameter int unsigned ADC_W = 10
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // bench requests
    input  wire logic             motion_tgl_i,
    input  wire logic [ADC_W-1:0] light_i,
    input  wire logic [ADC_W-1:0] sens_i,
    input  wire logic [ADC_W-1:0] delay_i,
    // device side
    output logic                  motion_o,
    output logic      [ADC_W-1:0] light_o,
    output logic      [ADC_W-1:0] sens_o,
    output logic      [ADC_W-1:0] delay_o
);
    logic tgl_q;

    // one pulse per bench toggle, on the block clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_q    <= 1'b0;
            motion_o <= 1'b0;
        end else begin
            tgl_q    <= motion_tgl_i;
            motion_o <= motion_tgl_i ^ tgl_q;
        end
    end

    // potentiometer and photocell levels, static between changes
    assign light_o = light_i;
    assign sens_o  = sens_i;
    assign delay_o = delay_i;
endmodule

`default_nettype wire

// >>> dv/mrd_tb.sv
// self-checking bench for the motion relay delay controller
`timescale 1ns/1ps
`default_nettype none

module tb;
    import mrd_pkg::*;
    localparam int unsigned TICK = 8;
    localparam int unsigned AW   = 10;
    // register port
    logic          clk;
    logic          rst_n;
    logic [3:0]    addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
    logic [31:0]   rdata;
    // motion and analog levels
    logic          tgl;
    logic          motion;
    logic [AW-1:0] light;
    logic [AW-1:0] light_p;
    logic [AW-1:0] sens_p;
    logic [AW-1:0] dly_p;
    logic [3:0]    sens_lvl;
    logic          relay;
    int            n_mismatch;
    int            n_checks;

    mrd_partner #(.ADC_W(AW)) u_partner (
        .clk_i(clk), .rst_n_i(rst_n), .motion_tgl_i(tgl),
        .light_i(light), .sens_i(10'h3FF), .delay_i(10'h240),
        .motion_o(motion), .light_o(light_p), .sens_o(sens_p),
        .delay_o(dly_p)
    );

    mrd_relay_ctrl #(.TICK_CYCLES(TICK), .ADC_W(AW)) u_dut (
        .MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .MOTION_EVT_I(motion),
        .SENS_LEVEL_O(sens_lvl), .SENS_SETTING_I(sens_p),
        .DELAY_SETTING_I(dly_p), .AMBIENT_LIGHT_I(light_p),
        .RELAY_DRIVE_O(relay)
    );

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(rdata & m, e);
        @(posedge clk);
    endtask

    // returns at the edge where the device takes the pulse
    task automatic mot();
        @(posedge clk);
        tgl <= ~tgl;
        repeat (2) @(posedge clk);
    endtask

    task automatic set_light(input logic [AW-1:0] v);
        @(posedge clk);
        light <= v;
        repeat (4) @(posedge clk);
    endtask

    // hang guard, well above the planned run
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        addr       = 4'h0;
        wdata      = 32'h0;
        wr         = 1'b0;
        rd         = 1'b0;
        tgl        = 1'b0;
        light      = 10'h28A;
        n_mismatch = 0;
        n_checks   = 0;
        repeat (12) @(posedge clk);
        chk({31'h0, relay}, 32'h0);
        rst_n <= 1'b1;
        // reset values, unmapped and read-only places
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h3);
        rd_chk(4'h4, 32'hFFFFFFFF, 32'h0);
        rd_chk(4'h8, 32'hFFFFFFFF, 32'h0);
        reg_wr(4'hC, 32'hFFF);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
        rd_chk(4'h1, 32'hFFFFFFFF, 32'h0);
        // settings sampled in turn, top level merged
        repeat (60) @(posedge clk);
        rd_chk(4'h8, 32'hFF, 32'h9E);
        chk({28'h0, sens_lvl}, 32'hE);
        // light one code under threshold refuses turn-on
        mot();
        repeat (5) @(posedge clk);
        chk({31'h0, relay}, 32'h0);
        set_light(10'h28B);
        mot();
        rd_chk(4'hC, 32'hFFF, 32'h00A);
        rd_chk(4'h4, 32'hFF, 32'h13);
        repeat (69) @(posedge clk);
        chk({31'h0, relay}, 32'h1);
        repeat (15) @(posedge clk);
        chk({31'h0, relay}, 32'h0);
        // extend in short window while dark, then a blocked retrigger
        mot();
        repeat (20) @(posedge clk);
        set_light(10'h000);
        mot();
        repeat (7) @(posedge clk);
        mot();
        repeat (10) @(posedge clk);
        rd_chk(4'hC, 32'hFFF, 32'h12A);
        rd_chk(4'h4, 32'h7, 32'h7);
        // inside the final minute motion is taken again
        repeat (1970) @(posedge clk);
        mot();
        repeat (18) @(posedge clk);
        rd_chk(4'hC, 32'hFFF, 32'h12A);
        // delayed detection off: immediate retrigger
        reg_wr(4'h0, 32'h1);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h1);
        mot();
        repeat (18) @(posedge clk);
        rd_chk(4'hC, 32'hFFF, 32'h12A);
        repeat (2370) @(posedge clk);
        chk({31'h0, relay}, 32'h1);
        repeat (80) @(posedge clk);
        chk({31'h0, relay}, 32'h0);
        // short window off: first motion runs the full delay
        reg_wr(4'h0, 32'h0);
        set_light(10'h3FF);
        mot();
        repeat (18) @(posedge clk);
        rd_chk(4'hC, 32'hFFF, 32'h12A);
        rd_chk(4'h4, 32'h7, 32'h7);
        summarize();
    end
endmodule

`default_nettype wire
